// ==== hdl/ces_pkg.sv ====
// package for the cpu error status register bank
package ces_pkg;
    // ****************************************
    // register map (word offsets on the bus)
    // ****************************************
    localparam logic [4:0] CES_ADDR_IFETCH_LO = 5'h00;
    localparam logic [4:0] CES_ADDR_IFETCH_HI = 5'h01;
    localparam logic [4:0] CES_ADDR_MMGMT_LO = 5'h02;
    localparam logic [4:0] CES_ADDR_MMGMT_HI = 5'h03;
    localparam logic [4:0] CES_ADDR_DCACHE_LO = 5'h04;
    localparam logic [4:0] CES_ADDR_DCACHE_HI = 5'h05;
    localparam logic [4:0] CES_ADDR_FAULT_VA_LO = 5'h06;
    localparam logic [4:0] CES_ADDR_FAULT_VA_HI = 5'h07;
    localparam logic [4:0] CES_ADDR_IRQ_STAT = 5'h08;
    localparam logic [4:0] CES_ADDR_IRQ_CLR = 5'h09;
    localparam logic [4:0] CES_ADDR_IRQ_EN = 5'h0A;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CES_IF_DPE_BIT = 30;
    localparam int CES_IF_TPE_BIT = 29;
    localparam int CES_MM_PROBE_BIT = 10;
    localparam int CES_MM_OPC_LSB = 4;
    localparam int CES_MM_FOW_BIT = 3;
    localparam int CES_MM_FOR_BIT = 2;
    localparam int CES_MM_ACV_BIT = 1;
    localparam int CES_MM_WR_BIT = 0;
    localparam int CES_DC_SEO_BIT = 4;
    localparam int CES_DC_LD_BIT = 3;
    localparam int CES_DC_ST_BIT = 2;
    localparam int CES_DC_P1_BIT = 1;
    localparam int CES_DC_P0_BIT = 0;

    // ****************************************
    // encodings, counts and reset values
    // ****************************************
    localparam logic [5:0] CES_OPC_PRIV_LOAD = 6'h03;
    localparam logic [5:0] CES_OPC_PRIV_STORE = 6'h07;
    localparam logic [2:0] CES_SEO_WINDOW = 3'h6;
    localparam logic [63:0] CES_RESET_64 = 64'h0000_0000_0000_0000;
    localparam logic [7:0] CES_IRQ_RESET = 8'h00;
    localparam int CES_NUM_EVT = 8;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic [4:0] adr;
        logic we;
        logic [3:0] sel;
        logic [31:0] dat;
    } ces_wb_req_t;

    typedef struct packed {
        logic valid;
        logic is_write;
        logic fault_on_write_flag;
        logic forr;
        logic access_violation_flag;
        logic priv_load;
        logic priv_store;
        logic [5:0] opcode;
        logic [63:0] va;
    } ces_mm_fault_t;

    typedef struct packed {
        logic icache_data_par;
        logic icache_tag_par;
        logic probe_tag_par;
        logic load_ecc;
        logic store_ecc;
        logic pipe1_tag_par;
        logic pipe0_tag_par;
        logic [5:0] probe_opcode;
        logic probe_is_write;
        logic [63:0] probe_va;
    } ces_err_evt_t;
endpackage

// ==== hdl/ces_regs.sv ====
// cpu error status register bank with wishbone slave and interrupt
`timescale 1ns/100ps
// Functional notes
// - fetch data parity sets bit 30, w1c
// - fetch tag parity sets bit 29, w1c
// - load/store probe tag parity sets bit 10
// - probe parity: correctable fault, capture address
// - faulting opcode captured in bits 9:4
// - privileged load shows 3, store 7
// - fault-on-write sets bit 3
// - fault-on-read sets bit 2
// - access violation sets bit 1
// - write transaction error sets bit 0
// - store ecc within 6 cycles sets bit 4
// - load or fill single-bit ecc sets bit 3
// - store ecc error sets bit 2
// - pipe one tag parity sets bit 1
// - pipe zero tag parity sets bit 0
// - pipe tag parity raises machine check
module ces_regs
    import ces_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire ces_err_evt_t err_evt_i,
    input wire ces_mm_fault_t mm_fault_i,
    output logic dstream_fault_o,
    output logic machine_check_o,
    output logic irq_o
);

    // ****************************************
    // bus decode
    // ****************************************
    ces_wb_req_t req;
    logic ack_q;
    logic err_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    wire hit_known = (req.adr <= CES_ADDR_IRQ_EN);
    wire wr_ok = bus_req && req.we && hit_known;
    wire [7:0] wmask_lo = {8{req.sel[0]}};
    wire [31:0] wmask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, wmask_lo};
    wire [31:0] w1 = req.dat & wmask;
    // only the low words hold writable bits, so the high halves need no decode
    wire wr_if = wr_ok && (req.adr == CES_ADDR_IFETCH_LO);
    wire wr_dc = wr_ok && (req.adr == CES_ADDR_DCACHE_LO);
    wire wr_iclr = wr_ok && (req.adr == CES_ADDR_IRQ_CLR);
    wire wr_ien = wr_ok && (req.adr == CES_ADDR_IRQ_EN);

    // one driver for the whole carrier; member-wise assigns would be four drivers
    assign req = {wb_adr_i, wb_we_i, wb_sel_i, wb_dat_i};

    // ****************************************
    // status registers
    // ****************************************
    logic [63:0] ifetch_error_status_q;
    logic [63:0] memmgmt_fault_status_q;
    logic [63:0] dcache_error_status_q;
    logic [63:0] fault_address_reg_q;
    logic [2:0] seo_cnt_q;

    // clear terms: w1c only; zero bits leave flags alone
    wire if_clr_dpe = wr_if && w1[CES_IF_DPE_BIT];
    wire if_clr_tpe = wr_if && w1[CES_IF_TPE_BIT];
    wire [4:0] dc_clr = wr_dc ? w1[4:0] : 5'h00;

    // second store ecc inside the window since the previous one
    wire seo_hit = err_evt_i.store_ecc && (seo_cnt_q != 3'h0);

    // probe parity fault and mm fault recording share one capture
    wire mm_load = mm_fault_i.valid || err_evt_i.probe_tag_par;
    wire [5:0] opc_sel = mm_fault_i.priv_load ? CES_OPC_PRIV_LOAD :
                         mm_fault_i.priv_store ? CES_OPC_PRIV_STORE :
                         mm_fault_i.opcode;
    wire [5:0] opc_cap = err_evt_i.probe_tag_par ? err_evt_i.probe_opcode : opc_sel;
    wire [63:0] mm_next = {53'h0, err_evt_i.probe_tag_par, opc_cap,
                           mm_fault_i.valid && mm_fault_i.fault_on_write_flag,
                           mm_fault_i.valid && mm_fault_i.forr,
                           mm_fault_i.valid && mm_fault_i.access_violation_flag,
                           mm_fault_i.valid ? mm_fault_i.is_write : err_evt_i.probe_is_write};

    // flag set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ifetch_error_status_q <= CES_RESET_64;
        end else begin
            ifetch_error_status_q[CES_IF_DPE_BIT] <= err_evt_i.icache_data_par ||
                (ifetch_error_status_q[CES_IF_DPE_BIT] && !if_clr_dpe);
            ifetch_error_status_q[CES_IF_TPE_BIT] <= err_evt_i.icache_tag_par ||
                (ifetch_error_status_q[CES_IF_TPE_BIT] && !if_clr_tpe);
        end
    end

    // read-only capture of the last recorded memory fault
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            memmgmt_fault_status_q <= CES_RESET_64;
            fault_address_reg_q <= CES_RESET_64;
        end else if (mm_load) begin
            memmgmt_fault_status_q <= mm_next;
            fault_address_reg_q <= err_evt_i.probe_tag_par ? err_evt_i.probe_va
                                                           : mm_fault_i.va;
        end
    end

    // store ecc window counter, reloaded by each store error
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seo_cnt_q <= 3'h0;
        end else if (err_evt_i.store_ecc) begin
            seo_cnt_q <= CES_SEO_WINDOW;
        end else if (seo_cnt_q != 3'h0) begin
            seo_cnt_q <= seo_cnt_q - 3'h1;
        end
    end

    // data cache flags, set before clear
    wire [4:0] dc_set = {seo_hit, err_evt_i.load_ecc, err_evt_i.store_ecc,
                         err_evt_i.pipe1_tag_par, err_evt_i.pipe0_tag_par};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dcache_error_status_q <= CES_RESET_64;
        end else begin
            dcache_error_status_q[4:0] <= dc_set | (dcache_error_status_q[4:0] & ~dc_clr);
        end
    end

    // ****************************************
    // fault and machine check outputs
    // ****************************************
    logic dstream_fault_q;
    logic machine_check_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dstream_fault_q <= 1'b0;
            machine_check_q <= 1'b0;
        end else begin
            dstream_fault_q <= err_evt_i.probe_tag_par;
            machine_check_q <= err_evt_i.pipe0_tag_par || err_evt_i.pipe1_tag_par;
        end
    end
    assign dstream_fault_o = dstream_fault_q;
    assign machine_check_o = machine_check_q;

    // ****************************************
    // interrupt status, clear and enable
    // ****************************************
    logic [7:0] irq_stat_q;
    logic [7:0] irq_en_q;
    logic irq_q;
    wire [7:0] irq_evt = {err_evt_i.icache_data_par, err_evt_i.icache_tag_par,
                          err_evt_i.probe_tag_par, mm_fault_i.valid, seo_hit,
                          err_evt_i.load_ecc || err_evt_i.store_ecc,
                          err_evt_i.pipe1_tag_par, err_evt_i.pipe0_tag_par};
    wire [7:0] irq_clr = wr_iclr ? w1[7:0] : 8'h00;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= CES_IRQ_RESET;
            irq_en_q <= CES_IRQ_RESET;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_evt | (irq_stat_q & ~irq_clr);
            if (wr_ien && req.sel[0]) begin
                irq_en_q <= req.dat[7:0];
            end
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end
    assign irq_o = irq_q;

    // ****************************************
    // read mux and ack
    // ****************************************
    always_comb begin
        rdat_d = 32'h0000_0000;
        unique case (req.adr)
            CES_ADDR_IFETCH_LO: rdat_d = ifetch_error_status_q[31:0];
            CES_ADDR_IFETCH_HI: rdat_d = ifetch_error_status_q[63:32];
            CES_ADDR_MMGMT_LO: rdat_d = memmgmt_fault_status_q[31:0];
            CES_ADDR_MMGMT_HI: rdat_d = memmgmt_fault_status_q[63:32];
            CES_ADDR_DCACHE_LO: rdat_d = dcache_error_status_q[31:0];
            CES_ADDR_DCACHE_HI: rdat_d = dcache_error_status_q[63:32];
            CES_ADDR_FAULT_VA_LO: rdat_d = fault_address_reg_q[31:0];
            CES_ADDR_FAULT_VA_HI: rdat_d = fault_address_reg_q[63:32];
            CES_ADDR_IRQ_STAT: rdat_d = {24'h0, irq_stat_q};
            CES_ADDR_IRQ_EN: rdat_d = {24'h0, irq_en_q};
            default: rdat_d = 32'h0000_0000; // clear register reads zero
        endcase
    end

    // one-cycle answer; unmapped address gets err instead of ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req && hit_known;
            err_q <= bus_req && !hit_known;
            rdat_q <= (bus_req && !req.we) ? rdat_d : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;

    // ****************************************
    // checks
    // ****************************************
    a_dpe_set_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        err_evt_i.icache_data_par |=> ifetch_error_status_q[30])
        else $error("fetch data parity flag not set");
    a_tpe_w1c_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (if_clr_tpe && !err_evt_i.icache_tag_par) |=> !ifetch_error_status_q[29])
        else $error("fetch tag parity flag not cleared");
    a_probe_fault_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        err_evt_i.probe_tag_par |=> memmgmt_fault_status_q[10] && dstream_fault_o
        && fault_address_reg_q == $past(err_evt_i.probe_va))
        else $error("probe parity fault not captured");
    a_priv_load_opc: assert property (@(posedge clk_i) disable iff (rst_i)
        (mm_fault_i.valid && mm_fault_i.priv_load && !err_evt_i.probe_tag_par)
        |=> memmgmt_fault_status_q[9:4] == 6'h03)
        else $error("privileged load opcode wrong");
    a_write_flag_cap: assert property (@(posedge clk_i) disable iff (rst_i)
        mm_fault_i.valid |=> memmgmt_fault_status_q[0] == $past(mm_fault_i.is_write))
        else $error("write flag wrong");
    a_seo_window_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        err_evt_i.store_ecc ##[1:6] err_evt_i.store_ecc |=> dcache_error_status_q[4])
        else $error("second error flag missed");
    a_seo_no_false: assert property (@(posedge clk_i) disable iff (rst_i)
        (!err_evt_i.store_ecc [*6] ##1 err_evt_i.store_ecc && !dcache_error_status_q[4])
        |=> !dcache_error_status_q[4])
        else $error("second error flag set outside window");
    a_pipe_mcheck: assert property (@(posedge clk_i) disable iff (rst_i)
        err_evt_i.pipe1_tag_par |=> dcache_error_status_q[1] && machine_check_o)
        else $error("pipe one parity not reported");
    a_zero_write_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_dc && !w1[0] && dcache_error_status_q[0]) |=> dcache_error_status_q[0])
        else $error("zero write cleared flag");
    a_irq_follows_en: assert property (@(posedge clk_i) disable iff (rst_i)
        |(irq_stat_q & irq_en_q) |=> irq_o)
        else $error("interrupt not raised");

    // ****************************************
    // further checks on flags, capture and bus
    // ****************************************

    // fetch tag parity event must stick
    a_tpe_set_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        err_evt_i.icache_tag_par |=> ifetch_error_status_q[29])
        else $error("fetch tag parity flag not set");

    // a one written to the data parity bit clears it
    a_dpe_w1c_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (if_clr_dpe && !err_evt_i.icache_data_par) |=> !ifetch_error_status_q[30])
        else $error("fetch data parity flag not cleared");

    // without a one-write the flag holds, whatever else is written
    a_if_zero_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        (!if_clr_dpe && ifetch_error_status_q[30]) |=> ifetch_error_status_q[30])
        else $error("fetch data parity flag lost");

    // probe parity records the probe's own opcode
    a_probe_opc_cap: assert property (@(posedge clk_i) disable iff (rst_i)
        err_evt_i.probe_tag_par
        |=> memmgmt_fault_status_q[9:4] == $past(err_evt_i.probe_opcode))
        else $error("probe opcode not captured");

    // privileged store alone reports its fixed code
    a_priv_store_opc: assert property (@(posedge clk_i) disable iff (rst_i)
        (mm_fault_i.valid && mm_fault_i.priv_store && !mm_fault_i.priv_load
        && !err_evt_i.probe_tag_par) |=> memmgmt_fault_status_q[9:4] == 6'h07)
        else $error("privileged store opcode wrong");

    // fault-on-write copied from the fault record
    a_fow_flag_cap: assert property (@(posedge clk_i) disable iff (rst_i)
        mm_fault_i.valid |=> memmgmt_fault_status_q[3] == $past(mm_fault_i.fault_on_write_flag))
        else $error("fault on write flag wrong");

    // fault-on-read copied from the fault record
    a_for_flag_cap: assert property (@(posedge clk_i) disable iff (rst_i)
        mm_fault_i.valid |=> memmgmt_fault_status_q[2] == $past(mm_fault_i.forr))
        else $error("fault on read flag wrong");

    // access violation copied from the fault record
    a_acv_flag_cap: assert property (@(posedge clk_i) disable iff (rst_i)
        mm_fault_i.valid |=> memmgmt_fault_status_q[1] == $past(mm_fault_i.access_violation_flag))
        else $error("access violation flag wrong");

    // read-only capture: bus writes must not disturb it
    a_mm_hold_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !mm_load |=> $stable(memmgmt_fault_status_q))
        else $error("memory fault status changed without a fault");

    // load or fill ecc error sets its flag
    a_ld_ecc_set: assert property (@(posedge clk_i) disable iff (rst_i)
        err_evt_i.load_ecc |=> dcache_error_status_q[3])
        else $error("load ecc flag not set");

    // store ecc sets its flag, even against a clear
    a_st_ecc_set: assert property (@(posedge clk_i) disable iff (rst_i)
        err_evt_i.store_ecc |=> dcache_error_status_q[2])
        else $error("store ecc flag not set");

    // pipe zero parity: flag and machine check
    a_p0_tag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        err_evt_i.pipe0_tag_par |=> dcache_error_status_q[0] && machine_check_o)
        else $error("pipe zero parity not reported");

    // no machine check without a pipe parity event
    a_mcheck_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !(err_evt_i.pipe0_tag_par || err_evt_i.pipe1_tag_par) |=> !machine_check_o)
        else $error("spurious machine check");

    // no data-stream fault without a probe parity event
    a_dfault_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !err_evt_i.probe_tag_par |=> !dstream_fault_o)
        else $error("spurious data stream fault");

    // window restarts at every store error
    a_seo_cnt_load: assert property (@(posedge clk_i) disable iff (rst_i)
        err_evt_i.store_ecc |=> seo_cnt_q == 3'h6)
        else $error("second error window not reloaded");

    // one written to pipe one flag clears it
    a_dc_w1c_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_dc && w1[1] && !err_evt_i.pipe1_tag_par) |=> !dcache_error_status_q[1])
        else $error("pipe one flag not cleared");

    // ack is a single-cycle pulse
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

    // unmapped index answers with err, never ack
    a_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && !hit_known) |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");

    // read data is zero outside the ack cycle
    a_dat_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");

    // interrupt drops once nothing enabled is pending
    a_irq_low_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !(|(irq_stat_q & irq_en_q)) |=> !irq_o)
        else $error("interrupt stuck high");
endmodule

// ==== testbench/test_cpu_error_status_regs.sv ====
// self-checking bench for the cpu error status register bank
`timescale 1ns/100ps
module test_cpu_error_status_regs
    import ces_pkg::*;
;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, wb_err_o, bus_err;
    logic dstream_fault_o, machine_check_o, irq_o;
    logic [4:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, wb_dat_o, rd;
    logic [63:0] v;
    ces_err_evt_t e, err_evt;
    ces_mm_fault_t f, mm_fault;
    int failures, n_compared, seed, r;

    ces_regs i_ces_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .err_evt_i(err_evt),
        .mm_fault_i(mm_fault), .dstream_fault_o(dstream_fault_o),
        .machine_check_o(machine_check_o), .irq_o(irq_o));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // classic single cycle; waits for ack or err, never assumes a latency
    task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && n < 20);
        if (n >= 20) failures++;
        rd = wb_dat_o;
        bus_err = wb_err_o;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        @(posedge clk_i);
    endtask

    task automatic rd64(input logic [4:0] a);
        wb(1'h0, a, 32'h0);
        v[31:0] = rd;
        wb(1'h0, a + 5'h1, 32'h0);
        v[63:32] = rd;
    endtask

    // one-cycle event pulse, then look at the registered side outputs
    task automatic ev(input ces_err_evt_t x, input logic df, input logic mc);
        err_evt <= x;
        @(posedge clk_i);
        err_evt <= '0;
        #1;
        chk("dstream_fault_o", {63'h0, df}, {63'h0, dstream_fault_o});
        chk("machine_check_o", {63'h0, mc}, {63'h0, machine_check_o});
        @(posedge clk_i);
    endtask

    task automatic mm(input ces_mm_fault_t x);
        mm_fault <= x;
        @(posedge clk_i);
        mm_fault <= '0;
        @(posedge clk_i);
    endtask

    // privileged load wins over privileged store, both over the raw opcode
    function automatic logic [63:0] mm_exp(input ces_mm_fault_t x);
        logic [5:0] opc;
        opc = x.priv_load ? CES_OPC_PRIV_LOAD : (x.priv_store ? CES_OPC_PRIV_STORE : x.opcode);
        return {54'h0, opc, x.fault_on_write_flag, x.forr, x.access_violation_flag, x.is_write};
    endfunction

    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ****************************************
    // clock, watchdog and main sequence
    // ****************************************
    initial begin
        clk_i = 1'h0;
        forever #12.5 clk_i = ~clk_i;
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        end_sim;
    end

    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
        wb_sel = 4'hF;
        err_evt = '0;
        mm_fault = '0;
        failures = 0;
        n_compared = 0;
        seed = 59750;
        rst_i = 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        for (int a = 0; a < 11; a++) begin
            if (a != 9) begin
                wb(1'h0, a[4:0], 32'h0);
                chk("reset value", 64'h0, {32'h0, rd});
            end
        end
        e = '0;
        e.icache_data_par = 1'h1;
        ev(e, 1'h0, 1'h0);
        rd64(CES_ADDR_IFETCH_LO);
        chk("ifetch status", 64'h4000_0000, v);
        e = '0;
        e.icache_tag_par = 1'h1;
        ev(e, 1'h0, 1'h0);
        wb(1'h1, CES_ADDR_IFETCH_LO, 32'h0);
        rd64(CES_ADDR_IFETCH_LO);
        chk("ifetch status", 64'h6000_0000, v);
        wb(1'h1, CES_ADDR_IFETCH_LO, 32'h4000_0000);
        rd64(CES_ADDR_IFETCH_LO);
        chk("ifetch status", 64'h2000_0000, v);
        // random faults, the first two force the privileged encodings
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            f = '0;
            {f.is_write, f.fault_on_write_flag, f.forr, f.access_violation_flag, f.priv_load, f.priv_store} = r[5:0];
            f.opcode = r[11:6];
            if (i == 0) {f.priv_load, f.priv_store} = 2'h3;
            if (i == 1) {f.priv_load, f.priv_store} = 2'h1;
            f.valid = 1'h1;
            f.va = {$random(seed), $random(seed)};
            mm(f);
            rd64(CES_ADDR_MMGMT_LO);
            chk("memmgmt status", mm_exp(f), v);
        end
        wb(1'h1, CES_ADDR_MMGMT_LO, 32'hFFFF_FFFF);
        rd64(CES_ADDR_MMGMT_LO);
        chk("memmgmt status", mm_exp(f), v);
        e = '0;
        e.probe_tag_par = 1'h1;
        e.probe_opcode = r[17:12];
        e.probe_is_write = 1'h1;
        e.probe_va = {$random(seed), $random(seed)};
        ev(e, 1'h1, 1'h0);
        rd64(CES_ADDR_MMGMT_LO);
        chk("memmgmt probe", {53'h0, 1'h1, e.probe_opcode, 4'h1}, v);
        rd64(CES_ADDR_FAULT_VA_LO);
        chk("fault address", e.probe_va, v);
        e = '0;
        e.load_ecc = 1'h1;
        ev(e, 1'h0, 1'h0);
        e = '0;
        e.pipe1_tag_par = 1'h1;
        ev(e, 1'h0, 1'h1);
        e = '0;
        e.pipe0_tag_par = 1'h1;
        ev(e, 1'h0, 1'h1);
        rd64(CES_ADDR_DCACHE_LO);
        chk("dcache status", 64'hB, v);
        wb(1'h1, CES_ADDR_DCACHE_LO, 32'h2);
        rd64(CES_ADDR_DCACHE_LO);
        chk("dcache status", 64'h9, v);
        wb(1'h1, CES_ADDR_DCACHE_LO, 32'h9);
        rd64(CES_ADDR_DCACHE_LO);
        chk("dcache status", 64'h0, v);
        // store errors seven, then six cycles apart: only the second pair is close enough
        for (int g = 7; g >= 6; g--) begin
            e = '0;
            e.store_ecc = 1'h1;
            ev(e, 1'h0, 1'h0);
            repeat (g - 2) @(posedge clk_i);
            ev(e, 1'h0, 1'h0);
            rd64(CES_ADDR_DCACHE_LO);
            chk("dcache second error", {59'h0, g == 6, 4'h4}, v);
            wb(1'h1, CES_ADDR_DCACHE_LO, 32'h14);
            rd64(CES_ADDR_DCACHE_LO);
            chk("dcache cleared", 64'h0, v);
        end
        // every event source has fired by now
        chk("irq_o masked", 64'h0, {63'h0, irq_o});
        wb(1'h1, CES_ADDR_IRQ_EN, 32'hFF);
        repeat (2) @(posedge clk_i);
        chk("irq_o enabled", 64'h1, {63'h0, irq_o});
        wb(1'h0, CES_ADDR_IRQ_STAT, 32'h0);
        chk("irq status", 64'hFF, {32'h0, rd});
        wb(1'h1, CES_ADDR_IRQ_EN, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("irq_o masked", 64'h0, {63'h0, irq_o});
        wb(1'h1, CES_ADDR_IRQ_EN, 32'hFF);
        wb(1'h1, CES_ADDR_IRQ_CLR, 32'hFF);
        repeat (2) @(posedge clk_i);
        chk("irq_o cleared", 64'h0, {63'h0, irq_o});
        ev(e, 1'h0, 1'h0);
        repeat (2) @(posedge clk_i);
        chk("irq_o raised", 64'h1, {63'h0, irq_o});
        wb(1'h0, 5'h1F, 32'h0);
        chk("bus error", 64'h1, {63'h0, bus_err});
        end_sim;
    end
endmodule
